/* jbs_pkg.sv */
package jbs_pkg;
   // instruction register and data register lengths
   localparam int IR_LEN = 10;
   localparam int DEVICE_IDENTIFICATION_LEN = 32;
   localparam int USER_DEFINED_CODE_LEN = 32;
   localparam int SIG_LEN = 16;
   localparam int BSR_LEN_DEFAULT = 96;
   // identification field positions (msb leftmost)
   localparam int ID_VER_POS = 28;
   localparam int ID_PART_POS = 12;
   localparam int ID_MFR_POS = 1;
   // arbitrary neutral identity values
   localparam logic [3:0] ID_VER_DEFAULT = 4'h2;
   localparam logic [15:0] ID_PART_DEFAULT = 16'hABCD;
   localparam logic [10:0] ID_MFR_DEFAULT = 11'h155;
   // opcodes are not documented; arbitrary choices
   localparam logic [9:0] OP_EXTEST = 10'h000;
   localparam logic [9:0] OP_SAMPLE = 10'h055;
   localparam logic [9:0] OP_DEVICE_IDENTIFICATION = 10'h059;
   localparam logic [9:0] OP_USER_DEFINED_CODE = 10'h007;
   localparam logic [9:0] OP_SIGREAD = 10'h079;
   localparam logic [9:0] OP_PROG_ENTER = 10'h2CC;
   localparam logic [9:0] OP_PROG_DONE = 10'h2F4;
   localparam logic [9:0] OP_PROG_EXIT = 10'h201;
   localparam logic [9:0] OP_BYPASS = 10'h3FF;
   // link timing: test clock half period at 250 MHz core clock
   localparam int CORE_CLK_MHZ = 250;
   localparam int TCK_HALF_NS = 80;
   localparam int TCK_HALF_CYC = (TCK_HALF_NS * CORE_CLK_MHZ + 999) / 1000;
   localparam int FIFO_DEPTH = 32;
   // test access port states
   typedef enum logic [3:0] {
      JBS_RESET, JBS_IDLE, JBS_SEL_DR, JBS_CAP_DR, JBS_SH_DR, JBS_EX1_DR,
      JBS_PAU_DR, JBS_EX2_DR, JBS_UPD_DR, JBS_SEL_IR, JBS_CAP_IR, JBS_SH_IR,
      JBS_EX1_IR, JBS_PAU_IR, JBS_EX2_IR, JBS_UPD_IR
   } jbs_tap_type;
   function automatic jbs_tap_type tap_next(input jbs_tap_type s, input logic tms);
      unique case (s)
         JBS_RESET: tap_next = tms ? JBS_RESET : JBS_IDLE;
         JBS_IDLE: tap_next = tms ? JBS_SEL_DR : JBS_IDLE;
         JBS_SEL_DR: tap_next = tms ? JBS_SEL_IR : JBS_CAP_DR;
         JBS_CAP_DR: tap_next = tms ? JBS_EX1_DR : JBS_SH_DR;
         JBS_SH_DR: tap_next = tms ? JBS_EX1_DR : JBS_SH_DR;
         JBS_EX1_DR: tap_next = tms ? JBS_UPD_DR : JBS_PAU_DR;
         JBS_PAU_DR: tap_next = tms ? JBS_EX2_DR : JBS_PAU_DR;
         JBS_EX2_DR: tap_next = tms ? JBS_UPD_DR : JBS_SH_DR;
         JBS_UPD_DR: tap_next = tms ? JBS_SEL_DR : JBS_IDLE;
         JBS_SEL_IR: tap_next = tms ? JBS_RESET : JBS_CAP_IR;
         JBS_CAP_IR: tap_next = tms ? JBS_EX1_IR : JBS_SH_IR;
         JBS_SH_IR: tap_next = tms ? JBS_EX1_IR : JBS_SH_IR;
         JBS_EX1_IR: tap_next = tms ? JBS_UPD_IR : JBS_PAU_IR;
         JBS_PAU_IR: tap_next = tms ? JBS_EX2_IR : JBS_PAU_IR;
         JBS_EX2_IR: tap_next = tms ? JBS_UPD_IR : JBS_SH_IR;
         JBS_UPD_IR: tap_next = tms ? JBS_SEL_DR : JBS_IDLE;
      endcase
   endfunction
endpackage

/* jbs_link_if.sv */
`timescale 1ns/1ps
// four-wire serial test link; the host makes the clock
interface jbs_link_if;
   logic tck; // test clock
   logic tms; // mode select
   logic tdi; // serial data into the device
   logic tdo; // serial data out of the device
   logic tdo_oe; // device drives tdo while high
   modport device (input tck, input tms, input tdi, output tdo, output tdo_oe);
   modport host (output tck, output tms, output tdi, input tdo, input tdo_oe);
endinterface

/* jbs_fifo.sv */
`timescale 1ns/1ps
// synchronous fifo with valid/ready on both sides
module jbs_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input wire logic core_clk, // clock
   input wire logic rst, // synchronous reset
   input wire logic in_valid, // write request
   output logic in_ready, // room available
   input wire logic [WIDTH-1:0] in_data, // write data
   output logic out_valid, // data available
   input wire logic out_ready, // read accept
   output logic [WIDTH-1:0] out_data // read data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_reg, rd_reg;
   logic [AW:0] cnt_reg;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
   assign out_valid = (cnt_reg != '0);
   assign out_data = mem[rd_reg];
   // pointers and occupancy
   always_ff @(posedge core_clk) begin
      if (rst) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end else begin
         if (push) wr_reg <= wr_reg + 1'b1;
         if (pop) rd_reg <= rd_reg + 1'b1;
         cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
   // storage needs no reset
   always_ff @(posedge core_clk) begin
      if (push) mem[wr_reg] <= in_data;
   end
endmodule

/* jbs_device.sv */
`timescale 1ns/1ps
// What this block does
// - test and programming share one four-wire link
// - programming tri-states user pins, weak pull-up
// - outputs off until completion flag is set
// - sample/preload captures pins, preloads pattern
// - external test drives chain, captures inputs
// - bypass puts one bit between tdi, tdo
// - identification register shifts out its value
// - id: version, part, manufacturer, one bit
// - user code shifts out 32-bit value
// - user code only on enhanced variants
// - signature read only on non-enhanced variants
// - user signature register is 16 bits
// - instruction register is ten bits
// - chain length is a variant parameter
// - enhanced parts accept adaptive or fixed sequence
// - non-enhanced parts need adaptive sequence
// - dedicated programming instructions on the link
// - identification lsb is fixed one
// - msb leftmost, constant one shifts first
module jbs_device #(
   parameter int BSR_LEN = jbs_pkg::BSR_LEN_DEFAULT, // chain cells
   parameter bit ENHANCED = 1'b1, // enhanced variant
   parameter logic [3:0] ID_VER = jbs_pkg::ID_VER_DEFAULT, // arbitrary value
   parameter logic [15:0] ID_PART = jbs_pkg::ID_PART_DEFAULT, // arbitrary value
   parameter logic [10:0] ID_MFR = jbs_pkg::ID_MFR_DEFAULT, // arbitrary value
   parameter logic [31:0] USER_CODE = 32'h0000_0000, // user code contents
   parameter logic [15:0] USER_SIG = 16'h0000 // signature contents
) (
   input wire logic core_clk, // core clock
   input wire logic rst, // synchronous reset
   jbs_link_if.device link, // serial test link
   input wire logic [BSR_LEN-1:0] pin_in, // pin input levels
   input wire logic [BSR_LEN-1:0] core_out, // core output values
   input wire logic [BSR_LEN-1:0] core_oe, // core output enables
   output logic [BSR_LEN-1:0] pin_out, // pin output values
   output logic [BSR_LEN-1:0] pin_oe, // pin output enables
   output logic pin_pullup, // weak pull-up on user pins
   output logic programming_complete_flag, // programming complete
   output logic in_system_programming // programming in progress
);
   // two-stage synchronisers for the link inputs
   logic [2:0] s1_reg, s2_reg;
   logic tck_d_reg;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         s1_reg <= '0;
         s2_reg <= '0;
         tck_d_reg <= 1'b0;
      end else begin
         s1_reg <= {link.tck, link.tms, link.tdi};
         s2_reg <= s1_reg;
         tck_d_reg <= s2_reg[2];
      end
   end
   wire tck_s = s2_reg[2];
   wire tms_s = s2_reg[1];
   wire tdi_s = s2_reg[0];
   wire tck_rise = tck_s && !tck_d_reg;
   wire tck_fall = !tck_s && tck_d_reg;

   // tap controller advanced on rising test clock
   jbs_pkg::jbs_tap_type st_reg;
   always_ff @(posedge core_clk) begin
      if (rst) st_reg <= jbs_pkg::JBS_RESET;
      else if (tck_rise) st_reg <= jbs_pkg::tap_next(st_reg, tms_s);
   end

   // instruction decode; unknown or unimplemented codes fall to bypass
   logic [9:0] ir_reg, irsh_reg;
   wire is_extest = (ir_reg == jbs_pkg::OP_EXTEST);
   wire is_sample = (ir_reg == jbs_pkg::OP_SAMPLE);
   wire is_device_identification = (ir_reg == jbs_pkg::OP_DEVICE_IDENTIFICATION);
   wire is_user = ENHANCED && (ir_reg == jbs_pkg::OP_USER_DEFINED_CODE);
   wire is_sig = !ENHANCED && (ir_reg == jbs_pkg::OP_SIGREAD);
   wire is_bsr = is_extest || is_sample;
   wire is_bypass = !(is_bsr || is_device_identification || is_user || is_sig);

   // identification word, msb leftmost, lsb fixed one
   wire [31:0] id_word = {ID_VER, ID_PART, ID_MFR, 1'b1};

   // data shift registers
   logic [BSR_LEN-1:0] bsr_reg, bsu_reg;
   logic [31:0] dr32_reg;
   logic [15:0] sig_reg;
   logic byp_reg, tdo_reg, oe_reg;
   wire cap_dr = tck_rise && (st_reg == jbs_pkg::JBS_CAP_DR);
   wire sh_dr = tck_rise && (st_reg == jbs_pkg::JBS_SH_DR);
   wire upd_dr = tck_rise && (st_reg == jbs_pkg::JBS_UPD_DR);
   wire cap_ir = tck_rise && (st_reg == jbs_pkg::JBS_CAP_IR);
   wire sh_ir = tck_rise && (st_reg == jbs_pkg::JBS_SH_IR);
   wire upd_ir = tck_rise && (st_reg == jbs_pkg::JBS_UPD_IR);
   wire tap_rst = tck_rise && (st_reg == jbs_pkg::JBS_RESET);

   // ten-bit instruction shift and update
   always_ff @(posedge core_clk) begin
      if (rst || tap_rst) begin
         irsh_reg <= 10'h000;
         ir_reg <= jbs_pkg::OP_DEVICE_IDENTIFICATION;
      end else begin
         if (cap_ir) irsh_reg <= 10'h001;
         else if (sh_ir) irsh_reg <= {tdi_s, irsh_reg[9:1]};
         if (upd_ir) ir_reg <= irsh_reg;
      end
   end

   // pin levels come from the board, so they pass two flip-flops first
   logic [BSR_LEN-1:0] pin1_reg, pin2_reg;
   always_ff @(posedge core_clk) begin
      pin1_reg <= pin_in;
      pin2_reg <= pin1_reg;
   end

   // boundary chain: capture pins, shift, update pattern
   // per cell under sample: a driven pin reads back the core value, others the pin level; extest captures pin levels
   wire [BSR_LEN-1:0] drv_val = (core_oe & core_out) | (~core_oe & pin2_reg);
   wire [BSR_LEN-1:0] cap_val = is_extest ? pin2_reg : drv_val;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         bsr_reg <= '0;
         bsu_reg <= '0;
      end else begin
         if (cap_dr && is_bsr) bsr_reg <= cap_val;
         else if (sh_dr && is_bsr) bsr_reg <= {tdi_s, bsr_reg[BSR_LEN-1:1]};
         if (upd_dr && is_bsr) bsu_reg <= bsr_reg; // preload
      end
   end

   // 32-bit id/user code, 16-bit signature, bypass
   always_ff @(posedge core_clk) begin
      if (rst) begin
         dr32_reg <= '0;
         sig_reg <= '0;
         byp_reg <= 1'b0;
      end else if (cap_dr) begin
         dr32_reg <= is_user ? USER_CODE : id_word;
         sig_reg <= USER_SIG;
         byp_reg <= 1'b0;
      end else if (sh_dr) begin
         dr32_reg <= {tdi_s, dr32_reg[31:1]}; // lsb first
         sig_reg <= {tdi_s, sig_reg[15:1]};
         byp_reg <= tdi_s;
      end
   end

   // serial output changes on falling test clock
   wire sel_ir = (st_reg == jbs_pkg::JBS_SH_IR);
   wire dr_bit = is_bsr ? bsr_reg[0] : (is_device_identification || is_user) ? dr32_reg[0] :
                 is_sig ? sig_reg[0] : byp_reg;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         tdo_reg <= 1'b0;
         oe_reg <= 1'b0;
      end else if (tck_fall) begin
         tdo_reg <= sel_ir ? irsh_reg[0] : dr_bit;
         oe_reg <= sel_ir || (st_reg == jbs_pkg::JBS_SH_DR);
      end
   end

   // programming session via dedicated instructions
   logic prog_reg, done_reg;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         prog_reg <= 1'b0;
         done_reg <= !ENHANCED; // non-enhanced parts have no flag
      end else if (upd_ir) begin
         if (irsh_reg == jbs_pkg::OP_PROG_ENTER) begin
            prog_reg <= 1'b1;
            if (ENHANCED) done_reg <= 1'b0;
         end else if (irsh_reg == jbs_pkg::OP_PROG_DONE && prog_reg && ENHANCED) begin
            done_reg <= 1'b1; // set last
         end else if (irsh_reg == jbs_pkg::OP_PROG_EXIT) begin
            prog_reg <= 1'b0;
         end
      end
   end

   // pin drive: programming and missing flag disable outputs
   wire pins_off = prog_reg || !done_reg;
   logic [BSR_LEN-1:0] pout_reg, poe_reg;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pout_reg <= '0;
         poe_reg <= '0;
      end else begin
         pout_reg <= is_extest ? bsu_reg : core_out;
         poe_reg <= pins_off ? '0 : (is_extest ? {BSR_LEN{1'b1}} : core_oe);
      end
   end
   assign pin_out = pout_reg;
   assign pin_oe = poe_reg;
   assign link.tdo = tdo_reg;
   assign link.tdo_oe = oe_reg;
   assign in_system_programming = prog_reg;
   assign programming_complete_flag = done_reg;
   // pull-up follows a registered copy of the programming state
   logic pu_reg;
   always_ff @(posedge core_clk) begin
      if (rst) pu_reg <= 1'b0;
      else pu_reg <= prog_reg;
   end
   assign pin_pullup = pu_reg;
endmodule

/* jbs_host.sv */
`timescale 1ns/1ps
// link controller: serialises queued shift commands onto the test link
// command word: {tms_seq, tdi_seq, nbits-1}; one bit per test clock period
module jbs_host #(
   parameter int NB = 16, // bits per command word
   parameter int DEPTH = jbs_pkg::FIFO_DEPTH // command queue depth
) (
   input wire logic core_clk, // core clock
   input wire logic rst, // synchronous reset
   jbs_link_if.host link, // serial test link
   input wire logic cmd_valid, // command offered
   output logic cmd_ready, // queue has room
   input wire logic [2*NB+4:0] cmd_data, // tms, tdi, count-1
   output logic rsp_valid, // captured tdo word ready (pulse)
   output logic [NB-1:0] rsp_data // captured tdo bits, last in msb; first in lsb only for NB-bit commands
);
   localparam int CW = 2*NB + 5;
   logic q_valid, q_ready;
   logic [CW-1:0] q_data;
   jbs_fifo #(.WIDTH(CW), .DEPTH(DEPTH)) u_q (
      .core_clk(core_clk), .rst(rst),
      .in_valid(cmd_valid), .in_ready(cmd_ready), .in_data(cmd_data),
      .out_valid(q_valid), .out_ready(q_ready), .out_data(q_data));

   // tdo arrives from another timing domain
   logic tdo1_reg, tdo2_reg;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         tdo1_reg <= 1'b0;
         tdo2_reg <= 1'b0;
      end else begin
         tdo1_reg <= link.tdo;
         tdo2_reg <= tdo1_reg;
      end
   end

   // divider, shift state; instruction loads are ten bits
   logic [7:0] div_reg;
   logic busy_reg, tck_reg, tms_reg, tdi_reg, rv_reg;
   logic [NB-1:0] tms_sh_reg, tdi_sh_reg, cap_reg;
   logic [4:0] left_reg;
   wire half = (div_reg == 8'(jbs_pkg::TCK_HALF_CYC - 1));
   assign q_ready = !busy_reg; // stalls the queue while a word shifts
   always_ff @(posedge core_clk) begin
      if (rst) begin
         div_reg <= '0;
         busy_reg <= 1'b0;
         tck_reg <= 1'b0;
         tms_reg <= 1'b1;
         tdi_reg <= 1'b0;
         tms_sh_reg <= '0;
         tdi_sh_reg <= '0;
         cap_reg <= '0;
         left_reg <= '0;
         rv_reg <= 1'b0;
      end else begin
         rv_reg <= 1'b0;
         if (!busy_reg) begin
            div_reg <= '0;
            if (q_valid) begin
               busy_reg <= 1'b1;
               {tms_sh_reg, tdi_sh_reg, left_reg} <= q_data;
               tms_reg <= q_data[CW-1];
               tdi_reg <= q_data[NB+4];
            end
         end else if (half) begin
            div_reg <= '0;
            tck_reg <= !tck_reg;
            if (!tck_reg) begin
               // rising edge: device samples, host captures tdo
               // read-back lets a controller adapt, or it may ignore it
               cap_reg <= {tdo2_reg, cap_reg[NB-1:1]};
            end else begin
               tms_sh_reg <= {tms_sh_reg[NB-2:0], 1'b0};
               tdi_sh_reg <= {tdi_sh_reg[NB-2:0], 1'b0};
               tms_reg <= tms_sh_reg[NB-2];
               tdi_reg <= tdi_sh_reg[NB-2];
               if (left_reg == '0) begin
                  busy_reg <= 1'b0;
                  rv_reg <= 1'b1;
               end else begin
                  left_reg <= left_reg - 5'd1;
               end
            end
         end else begin
            div_reg <= div_reg + 8'd1;
         end
      end
   end
   assign link.tck = tck_reg;
   assign link.tms = tms_reg;
   assign link.tdi = tdi_reg;
   assign rsp_valid = rv_reg;
   assign rsp_data = cap_reg;
endmodule

/* jbs_link_chk.sv */
`timescale 1ns/1ps
// watches the four-wire link where both ends are design code
module jbs_link_chk (
   input wire logic core_clk, // core clock
   input wire logic rst, // synchronous reset
   input wire logic tck, // test clock
   input wire logic tms, // mode select
   input wire logic tdi, // data into device
   input wire logic tdo, // data out of device
   input wire logic tdo_oe // device drives tdo
);
   localparam int HALF = jbs_pkg::TCK_HALF_CYC;
   logic [7:0] lo_cnt_reg;
   // low-phase length; saturates so idle gaps between frames never wrap
   always_ff @(posedge core_clk) begin
      if (rst || tck) begin
         lo_cnt_reg <= 8'h00;
      end else if (lo_cnt_reg != 8'hFF) begin
         lo_cnt_reg <= lo_cnt_reg + 8'h01;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // high phase of one bit period: exactly twenty core cycles
   sequence high_run;
      tck [*8] ##12 tck ##1 !tck;
   endsequence
   a_tck_high_time: assert property ($rose(tck) |-> high_run)
      else $error("test clock high phase has the wrong length");
   a_tck_low_time: assert property ($rose(tck) |-> lo_cnt_reg >= HALF)
      else $error("test clock low phase too short");
   a_tck_low_min: assert property ($fell(tck) |-> !tck [*8])
      else $error("test clock rose again too soon");
   a_tms_steady: assert property (tck |-> $stable(tms))
      else $error("mode select moved while test clock high");
   a_tdi_steady: assert property (tck |-> $stable(tdi))
      else $error("serial input moved while test clock high");
   a_tdo_after_fall: assert property ($changed(tdo) |-> !tck && lo_cnt_reg inside {[1:6]})
      else $error("serial output changed away from a falling edge");
   a_oe_after_fall: assert property ($changed(tdo_oe) |-> !tck && lo_cnt_reg inside {[1:6]})
      else $error("output enable changed away from a falling edge");
   a_link_reset_idle: assert property ($fell(rst) |-> !tck && tms && !tdo_oe)
      else $error("link not idle after reset");
endmodule

/* test_jtag_boundary_scan_isp_port.sv */
`timescale 1ns/1ps
// drives the host end with shift commands and watches both ends
module test_jtag_boundary_scan_isp_port;
   typedef struct packed {logic [9:0] op; logic [10:0] tdi; logic [10:0] exp;} jbs_row_type;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic cmd_valid = 1'b0;
   logic cmd_ready;
   logic [36:0] cmd_data = 37'h0;
   logic rsp_valid;
   logic [15:0] rsp_data;
   logic [15:0] last_rsp = 16'h0;
   logic [95:0] pin_in = {24{4'hA}};
   logic [95:0] core_out = {24{4'h6}};
   logic [95:0] core_oe = {24{4'h3}};
   logic [95:0] pin_out, pin_oe;
   logic pin_pullup, flag, isp;
   int mismatches = 0, checked = 0, cycles = 0, rsp_seen = 0, acc = 0, base = 0;
   jbs_row_type rows [6];
   jbs_link_if link ();
   always #2 core_clk = ~core_clk;
   jbs_host #(.NB(16)) u_jbs_host (.core_clk(core_clk), .rst(rst), .link(link),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_data(cmd_data),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data));
   jbs_device #(.USER_CODE(32'h1234_5678)) u_jbs_device (.core_clk(core_clk), .rst(rst),
      .link(link), .pin_in(pin_in), .core_out(core_out), .core_oe(core_oe),
      .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
      .programming_complete_flag(flag), .in_system_programming(isp));
   jbs_link_chk u_jbs_link_chk (.core_clk(core_clk), .rst(rst), .tck(link.tck),
      .tms(link.tms), .tdi(link.tdi), .tdo(link.tdo), .tdo_oe(link.tdo_oe));
   task automatic check(input logic [127:0] seen, input logic [127:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic conclude;
      if (mismatches == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // one full sixteen-bit frame; waits for its answer before returning
   task automatic run(input logic [15:0] t, input logic [15:0] d);
      int n;
      n = rsp_seen;
      @(posedge core_clk);
      cmd_valid <= 1'b1;
      cmd_data <= {t, d, 5'h0F};
      do @(posedge core_clk); while (cmd_ready !== 1'b1);
      cmd_valid <= 1'b0;
      while (rsp_seen == n) @(posedge core_clk);
   endtask
   // idle -> shift-ir, ten bits lsb first, update, back to idle
   task automatic ir_load(input logic [9:0] op);
      logic [15:0] d;
      d = 16'h0000;
      for (int k = 0; k < 10; k++) d[11-k] = op[k];
      run(16'hC006, d);
   endtask
   // idle -> shift-dr, eleven bits out on response bits 13:3, back to idle
   task automatic dr_read(input logic [10:0] x);
      logic [15:0] d;
      d = 16'h0000;
      for (int k = 0; k < 11; k++) d[12-k] = x[k];
      run(16'h8006, d);
   endtask
   // answers are kept here; a hang is cut short by the cycle ceiling
   always @(posedge core_clk) begin
      cycles++;
      if (rsp_valid === 1'b1) begin
         rsp_seen++;
         last_rsp = rsp_data;
      end
      if (cycles == 60000) begin
         mismatches++;
         conclude();
      end
   end
   initial begin
      rows[0] = '{jbs_pkg::OP_DEVICE_IDENTIFICATION, 11'h000, {jbs_pkg::ID_MFR_DEFAULT[9:0], 1'b1}};
      rows[1] = '{jbs_pkg::OP_USER_DEFINED_CODE, 11'h000, 11'h678};
      rows[2] = '{jbs_pkg::OP_BYPASS, 11'h2B5, 11'h56A};
      rows[3] = '{jbs_pkg::OP_SIGREAD, 11'h0F3, 11'h1E6};
      rows[4] = '{10'h123, 11'h7FF, 11'h7FE};
      rows[5] = '{jbs_pkg::OP_SAMPLE, 11'h5C3, 11'h2AA};
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      @(posedge core_clk);
      check({link.tck, link.tms, link.tdo_oe, isp, flag}, 5'h08);
      check(pin_oe, 96'h0);
      run(16'hFFFE, 16'h0000);
      dr_read(11'h000);
      check(last_rsp[13:3], rows[0].exp);
      // programming: pins off and pulled up until the flag is set and we leave
      ir_load(jbs_pkg::OP_PROG_ENTER);
      check({isp, pin_pullup, flag, pin_oe}, {3'h6, 96'h0});
      ir_load(jbs_pkg::OP_PROG_DONE); // flag programmed last, fixed sequence
      check({isp, flag, pin_oe}, {2'h3, 96'h0});
      ir_load(jbs_pkg::OP_PROG_EXIT);
      check({isp, pin_pullup, flag}, 3'h1);
      check(pin_oe, core_oe);
      for (int i = 0; i < 6; i++) begin
         ir_load(rows[i].op);
         dr_read(rows[i].tdi);
         check(last_rsp[13:3], rows[i].exp);
      end
      // preloaded pattern now lands on the top cells of the chain
      ir_load(jbs_pkg::OP_EXTEST);
      check(pin_out[95:85], 11'h5C3);
      check(pin_oe, {24{4'hF}});
      pin_in <= {24{4'h5}};
      dr_read(11'h000);
      check(last_rsp[13:3], 11'h555);
      // fill the command queue until refused, then drain it completely
      base = rsp_seen;
      cmd_data <= {16'h0000, 16'h0000, 5'h0F};
      cmd_valid <= 1'b1;
      do begin
         @(posedge core_clk);
         if (cmd_ready === 1'b1) acc++;
      end while (cmd_ready === 1'b1 && acc < 40);
      cmd_valid <= 1'b0;
      check(acc > 31 && acc < 35, 1'h1);
      while (rsp_seen < base + acc) @(posedge core_clk);
      check(rsp_seen - base, acc);
      conclude();
   end
endmodule
